// ===== rtl/dtum_lim_tmr.sv
// cycle counter with a limit check, used for each update timing watch
// assumes run is a same-clock level; a zero limit never reports
`timescale 1ns/1ps
module dtum_lim_tmr #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// control
	input wire logic run,
	input wire logic [W-1:0] limit,
	// results
	output logic [W-1:0] count,
	output logic over
);
	logic [W-1:0] cnt_q;
	logic fired_q;

	// one pulse when the watched level has lasted past the limit
	assign over = run && (limit != '0) && (cnt_q == limit) && !fired_q;
	assign count = cnt_q;

	// count while running, clear when the level drops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
			fired_q <= 1'b0;
		end else if (!run) begin
			cnt_q <= '0;
			fired_q <= 1'b0;
		end else begin
			if (cnt_q != '1)
				cnt_q <= cnt_q + 1'b1;
			if (over)
				fired_q <= 1'b1;
		end
	end
endmodule // dtum_lim_tmr

// ===== rtl/dtum_pkg.sv
// types shared by the dfi timing and update monitor
// assumes dtum_regs.svh supplies the numeric constants
package dtum_pkg;

	// pins arriving from the phy
	typedef struct packed {
		logic ctrlupd_ack;
		logic phyupd_req;
		logic [1:0] phyupd_type;
		logic rddata_valid;
	} dtum_dfi_in_t;

	// pins driven toward the phy
	typedef struct packed {
		logic ctrlupd_req;
		logic phyupd_ack;
		logic [1:0] dram_clk_disable;
	} dtum_dfi_out_t;

	// signals from the controller core, same clock
	typedef struct packed {
		logic ctrlupd_want;
		logic rddata_en;
		logic [5:0] cas_lat;
		logic [5:0] wr_lat;
		logic mem_rst_valid;
	} dtum_core_t;

	typedef enum logic {CU_IDLE, CU_REQ} dtum_cu_state_t;
	typedef enum logic {PU_IDLE, PU_ACK} dtum_pu_state_t;

endpackage

// ===== rtl/dtum_regs.svh
// register map, field positions and reset values of the dfi timing and update monitor
// assumes a flat 32-bit register port whose addresses are full byte addresses
`ifndef DTUM_REGS_SVH
`define DTUM_REGS_SVH

// register byte addresses
`define DTUM_A_DLL 32'h4000_d578
`define DTUM_A_LAT 32'h4000_d57c
`define DTUM_A_CUL 32'h4000_d580
`define DTUM_A_P01 32'h4000_d584
`define DTUM_A_P23 32'h4000_d588
`define DTUM_A_ACK 32'h4000_d58c
`define DTUM_A_PER 32'h4000_d590
`define DTUM_A_CLK 32'h4000_d594
`define DTUM_A_WLE 32'h4000_d598
`define DTUM_A_WLR 32'h4000_d59c
`define DTUM_A_WLM 32'h4000_d5a0
`define DTUM_A_WLX 32'h4000_d5a4
`define DTUM_A_CMD 32'h4000_d5e0

// reset values
`define DTUM_RST_CMD_DLY 4'h2
`define DTUM_RST_WORD 32'h0000_0000

// update error bit positions
`define DTUM_ERR_PERIOD 0
`define DTUM_ERR_CU_MAX 1
`define DTUM_ERR_TYPE0 2
`define DTUM_ERR_ACK 6

// command register bit positions
`define DTUM_CMD_REQ 0
`define DTUM_CMD_ERR_LO 8
`define DTUM_CMD_LATE 16

// cycles spent in the pin synchroniser
`define DTUM_SYNC_LAT 7'h02

`endif

// ===== rtl/dtum_top.sv
// dfi timing registers, memory clock gating and update handshake monitor
// assumes phy pins are asynchronous and core signals share sys_clk
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "dtum_regs.svh"
module dtum_top import dtum_pkg::*; #(
	parameter logic [3:0] CTRLUPD_MIN = 4'h4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// controller core
	input wire dtum_core_t core_in,
	// dfi pins
	input wire dtum_dfi_in_t dfi_in,
	output dtum_dfi_out_t dfi_out,
	// status
	output logic [1:0] mem_clk_off,
	output logic update_irq
);
	// configuration registers
	logic [23:0] dll_q;
	logic [5:0] phy_rdlat_q;
	logic [13:0] cu_max_q;
	logic [1:0] clk_dis_q;
	logic [31:0] p01_q;
	logic [31:0] p23_q;
	logic [13:0] ack_lim_q;
	logic [31:0] period_q;
	logic [3:0] off_dly_q;
	logic [3:0] cmd_dly_q;
	logic [5:0] wr_trim_q;
	logic [5:0] rd_trim_q;
	logic [9:0] wl_gap_q;
	logic [7:0] wl_en_q;
	logic [3:0] on_dly_q;
	logic [31:0] wl_resp_q;
	logic [31:0] wl_max_q;
	logic [31:0] wl_misc_q;
	// state
	dtum_dfi_in_t sync1_q;
	dtum_dfi_in_t sync2_q;
	dtum_dfi_out_t dfi_out_q;
	dtum_cu_state_t cu_q;
	dtum_cu_state_t cu_d;
	dtum_pu_state_t pu_q;
	dtum_pu_state_t pu_d;
	logic [1:0] ptype_q;
	logic sw_pend_q;
	logic [6:0] err_q;
	logic irq_q;
	logic rd_wait_q;
	logic [7:0] rd_cnt_q;
	logic rd_late_q;
	logic [1:0] clk_off_q;
	logic [3:0] gate_cnt_q [2];
	logic [31:0] rdata_q;

	// saturating subtract used for both computed latencies
	function automatic logic [5:0] sat_sub(input logic [6:0] a, input logic [6:0] b);
		logic [6:0] r;
		r = (a > b) ? (a - b) : 7'h00;
		sat_sub = (r > 7'h3f) ? 6'h3f : r[5:0];
	endfunction

	// write strobes per register
	wire w_dll = reg_wr && (reg_addr == `DTUM_A_DLL);
	wire w_lat = reg_wr && (reg_addr == `DTUM_A_LAT);
	wire w_cul = reg_wr && (reg_addr == `DTUM_A_CUL);
	wire w_p01 = reg_wr && (reg_addr == `DTUM_A_P01);
	wire w_p23 = reg_wr && (reg_addr == `DTUM_A_P23);
	wire w_ack = reg_wr && (reg_addr == `DTUM_A_ACK);
	wire w_per = reg_wr && (reg_addr == `DTUM_A_PER);
	wire w_clk = reg_wr && (reg_addr == `DTUM_A_CLK);
	wire w_wle = reg_wr && (reg_addr == `DTUM_A_WLE);
	wire w_wlr = reg_wr && (reg_addr == `DTUM_A_WLR);
	wire w_wlm = reg_wr && (reg_addr == `DTUM_A_WLM);
	wire w_wlx = reg_wr && (reg_addr == `DTUM_A_WLX);
	wire w_cmd = reg_wr && (reg_addr == `DTUM_A_CMD);

	// computed latencies, command path delay taken out
	wire [5:0] rd_en_lat = sat_sub({1'b0, core_in.cas_lat}, {3'b000, cmd_dly_q});
	wire [6:0] wr_sum = {1'b0, core_in.wr_lat} + {1'b0, wr_trim_q};
	wire [5:0] wr_lat = sat_sub(wr_sum, {3'b000, cmd_dly_q});

	// latency, dll and control update register writes
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dll_q <= 24'h00_0000;
			phy_rdlat_q <= 6'h00;
			cu_max_q <= 14'h0000;
			clk_dis_q <= 2'b00;
		end else begin
			if (w_dll)
				dll_q <= reg_wdata[31:8];
			if (w_lat)
				phy_rdlat_q <= reg_wdata[21:16];
			if (w_cul) begin
				cu_max_q <= reg_wdata[29:16];
				clk_dis_q <= reg_wdata[1:0];
			end
		end
	end

	// update limit register writes
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			p01_q <= `DTUM_RST_WORD;
			p23_q <= `DTUM_RST_WORD;
			ack_lim_q <= 14'h0000;
			period_q <= `DTUM_RST_WORD;
		end else begin
			if (w_p01)
				p01_q <= reg_wdata;
			if (w_p23)
				p23_q <= reg_wdata;
			if (w_ack)
				ack_lim_q <= reg_wdata[13:0];
			if (w_per)
				period_q <= reg_wdata;
		end
	end

	// clock delay and trim register writes
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			off_dly_q <= 4'h0;
			cmd_dly_q <= `DTUM_RST_CMD_DLY;
			wr_trim_q <= 6'h00;
			rd_trim_q <= 6'h00;
			on_dly_q <= 4'h0;
		end else begin
			if (w_clk) begin
				off_dly_q <= reg_wdata[27:24];
				cmd_dly_q <= reg_wdata[19:16];
				wr_trim_q <= reg_wdata[13:8];
				rd_trim_q <= reg_wdata[5:0];
			end
			if (w_wle)
				on_dly_q <= reg_wdata[3:0];
		end
	end

	// write-leveling fields are storage only
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wl_gap_q <= 10'h000;
			wl_en_q <= 8'h00;
			wl_resp_q <= `DTUM_RST_WORD;
			wl_max_q <= `DTUM_RST_WORD;
			wl_misc_q <= `DTUM_RST_WORD;
		end else begin
			if (w_wle) begin
				wl_gap_q <= reg_wdata[25:16];
				wl_en_q <= reg_wdata[15:8];
			end
			if (w_wlr)
				wl_resp_q <= reg_wdata;
			if (w_wlm)
				wl_max_q <= reg_wdata;
			if (w_wlx)
				wl_misc_q <= reg_wdata;
		end
	end

	// two-flop synchroniser for phy pins
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= dfi_in;
			sync2_q <= sync1_q;
		end
	end

	// timer results
	logic [31:0] per_cnt;
	logic [31:0] cu_cnt;
	logic per_over;
	logic cu_over;
	logic ack_over;
	logic typ_over;

	// control update scheduling
	wire per_due = (period_q != 32'h0000_0000) && ((per_cnt + 32'h0000_0001) >= period_q);
	wire cu_start = (cu_q == CU_IDLE) && (core_in.ctrlupd_want || sw_pend_q || per_due);
	wire cu_held = ({28'h000_0000, CTRLUPD_MIN} <= (cu_cnt + 32'h0000_0001));
	wire cu_done = (cu_q == CU_REQ) && cu_held && sync2_q.ctrlupd_ack;

	// interval since the last control update request
	dtum_lim_tmr #(.W(32)) u_per (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.run(!cu_start),
		.limit(period_q),
		.count(per_cnt),
		.over(per_over)
	);

	// control update request length
	dtum_lim_tmr #(.W(32)) u_cu (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.run(cu_q == CU_REQ),
		.limit(32'(cu_max_q)),
		.count(cu_cnt),
		.over(cu_over)
	);

	// control update state
	always_comb begin
		cu_d = cu_q;
		case (cu_q)
			CU_IDLE: begin
				if (cu_start)
					cu_d = CU_REQ;
			end
			CU_REQ: begin
				if (cu_done)
					cu_d = CU_IDLE;
			end
			default: cu_d = CU_IDLE;
		endcase
	end

	// phy update ack is held off while a control update runs
	wire pu_grant = sync2_q.phyupd_req && (cu_q == CU_IDLE) && !cu_start;
	wire [15:0] t_lim = ptype_q[1] ? (ptype_q[0] ? p23_q[31:16] : p23_q[15:0])
		: (ptype_q[0] ? p01_q[31:16] : p01_q[15:0]);

	// phy update state
	always_comb begin
		pu_d = pu_q;
		case (pu_q)
			PU_IDLE: begin
				if (pu_grant)
					pu_d = PU_ACK;
			end
			PU_ACK: begin
				if (!sync2_q.phyupd_req)
					pu_d = PU_IDLE;
			end
			default: pu_d = PU_IDLE;
		endcase
	end

	// time from phy request to our ack
	dtum_lim_tmr #(.W(14)) u_ack (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.run(sync2_q.phyupd_req && (pu_q == PU_IDLE)),
		.limit(ack_lim_q),
		.count(),
		.over(ack_over)
	);

	// time the phy keeps its request up after our ack
	dtum_lim_tmr #(.W(16)) u_typ (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.run(sync2_q.phyupd_req && (pu_q == PU_ACK)),
		.limit(t_lim),
		.count(),
		.over(typ_over)
	);

	// violation sources, one bit per limit
	wire [3:0] typ_hit = typ_over ? (4'h1 << ptype_q) : 4'h0;
	wire [6:0] err_set = {ack_over, typ_hit, cu_over, per_over};
	wire [6:0] err_clr = w_cmd ? reg_wdata[14:8] : 7'h00;

	// handshake state and dfi outputs
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cu_q <= CU_IDLE;
			pu_q <= PU_IDLE;
			ptype_q <= 2'b00;
			dfi_out_q <= '0;
		end else begin
			cu_q <= cu_d;
			pu_q <= pu_d;
			if (pu_grant && (pu_q == PU_IDLE))
				ptype_q <= sync2_q.phyupd_type;
			dfi_out_q.ctrlupd_req <= (cu_d == CU_REQ);
			dfi_out_q.phyupd_ack <= (pu_d == PU_ACK);
			dfi_out_q.dram_clk_disable <= clk_dis_q;
		end
	end

	// sticky errors, a new violation beats a clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			err_q <= 7'h00;
			irq_q <= 1'b0;
			sw_pend_q <= 1'b0;
		end else begin
			err_q <= (err_q & ~err_clr) | err_set;
			irq_q <= |err_set;
			if (w_cmd && reg_wdata[`DTUM_CMD_REQ])
				sw_pend_q <= 1'b1;
			else if (cu_start)
				sw_pend_q <= 1'b0;
		end
	end

	// read valid window: phy read latency plus trim plus pin sync
	wire [7:0] rd_win = {2'b00, phy_rdlat_q} + {2'b00, rd_trim_q} + {1'b0, `DTUM_SYNC_LAT};
	wire rd_miss = rd_wait_q && !sync2_q.rddata_valid && (rd_cnt_q >= rd_win);
	wire late_clr = w_cmd && reg_wdata[`DTUM_CMD_LATE];

	// watch one read enable at a time for its valid; enables while waiting are ignored
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_wait_q <= 1'b0;
			rd_cnt_q <= 8'h00;
			rd_late_q <= 1'b0;
		end else begin
			if (sync2_q.rddata_valid || rd_miss) begin
				rd_wait_q <= 1'b0;
				rd_cnt_q <= 8'h00;
			end else if (core_in.rddata_en && !rd_wait_q) begin
				rd_wait_q <= 1'b1;
				rd_cnt_q <= 8'h00;
			end else if (rd_wait_q) begin
				rd_cnt_q <= rd_cnt_q + 8'h01;
			end
			if (rd_miss)
				rd_late_q <= 1'b1;
			else if (late_clr)
				rd_late_q <= 1'b0;
		end
	end

	// per select delay before the memory clock follows the strobe
	logic [3:0] gate_dly [2];
	assign gate_dly[0] = dfi_out_q.dram_clk_disable[0] ? off_dly_q : on_dly_q;
	assign gate_dly[1] = dfi_out_q.dram_clk_disable[1] ? off_dly_q : on_dly_q;

	// memory clock state per chip select
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_off_q <= 2'b00;
			gate_cnt_q[0] <= 4'h0;
			gate_cnt_q[1] <= 4'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (dfi_out_q.dram_clk_disable[i] == clk_off_q[i]) begin
					gate_cnt_q[i] <= 4'h0;
				end else if (({1'b0, gate_cnt_q[i]} + 5'h01) >= {1'b0, gate_dly[i]}) begin
					clk_off_q[i] <= dfi_out_q.dram_clk_disable[i];
					gate_cnt_q[i] <= 4'h0;
				end else begin
					gate_cnt_q[i] <= gate_cnt_q[i] + 4'h1;
				end
			end
		end
	end

	// read data words
	wire [31:0] dll_word = {dll_q, 7'h00, core_in.mem_rst_valid};
	wire [31:0] lat_word = {2'b00, rd_en_lat, 2'b00, phy_rdlat_q, 1'b0, err_q, 2'b00, wr_lat};
	wire [31:0] cul_word = {2'b00, cu_max_q, 4'h0, CTRLUPD_MIN, 6'h00, clk_dis_q};
	wire [31:0] clk_word = {4'h0, off_dly_q, 4'h0, cmd_dly_q, 2'b00, wr_trim_q, 2'b00, rd_trim_q};
	wire [31:0] wle_word = {6'h00, wl_gap_q, wl_en_q, 4'h0, on_dly_q};
	wire [31:0] cmd_word = {6'h00, clk_off_q, 7'h00, rd_late_q, 1'b0, err_q, 5'h00,
		dfi_out_q.phyupd_ack, dfi_out_q.ctrlupd_req, sw_pend_q};

	// read select, unmapped addresses read zero
	wire [31:0] rd_mux =
		(reg_addr == `DTUM_A_DLL) ? dll_word :
		(reg_addr == `DTUM_A_LAT) ? lat_word :
		(reg_addr == `DTUM_A_CUL) ? cul_word :
		(reg_addr == `DTUM_A_P01) ? p01_q :
		(reg_addr == `DTUM_A_P23) ? p23_q :
		(reg_addr == `DTUM_A_ACK) ? {18'h0_0000, ack_lim_q} :
		(reg_addr == `DTUM_A_PER) ? period_q :
		(reg_addr == `DTUM_A_CLK) ? clk_word :
		(reg_addr == `DTUM_A_WLE) ? wle_word :
		(reg_addr == `DTUM_A_WLR) ? wl_resp_q :
		(reg_addr == `DTUM_A_WLM) ? wl_max_q :
		(reg_addr == `DTUM_A_WLX) ? wl_misc_q :
		(reg_addr == `DTUM_A_CMD) ? cmd_word : `DTUM_RST_WORD;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			rdata_q <= `DTUM_RST_WORD;
		else
			rdata_q <= reg_rd ? rd_mux : `DTUM_RST_WORD;
	end

	// outputs straight from flops
	assign reg_rdata = rdata_q;
	assign dfi_out = dfi_out_q;
	assign mem_clk_off = clk_off_q;
	assign update_irq = irq_q;
endmodule // dtum_top

// ===== tb/dtum_checker.sv
// port assertions for the dfi timing and update monitor
// assumes binding to dtum_top, one clock domain, phy model acking updates
`timescale 1ns/1ps
`include "dtum_regs.svh"
module dtum_checker import dtum_pkg::*; #(
	parameter logic [3:0] CTRLUPD_MIN = 4'h4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// core and dfi
	input wire dtum_core_t core_in,
	input wire dtum_dfi_in_t dfi_in,
	input wire dtum_dfi_out_t dfi_out,
	// status
	input wire logic [1:0] mem_clk_off,
	input wire logic update_irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// steps of a control update: start, then minimum hold
	sequence s_cu_start;
		core_in.ctrlupd_want && !dfi_out.ctrlupd_req;
	endsequence
	sequence s_cu_hold;
		dfi_out.ctrlupd_req [*4];
	endsequence
	a_cu_start: assert property (s_cu_start |=> dfi_out.ctrlupd_req)
		else $error("control update did not start");
	a_cu_min_hold: assert property ($rose(dfi_out.ctrlupd_req) |-> s_cu_hold)
		else $error("control update request too short");
	a_cu_release: assert property ($fell(dfi_out.ctrlupd_req) |-> $past(dfi_in.ctrlupd_ack, 3))
		else $error("control update dropped without ack");
	a_pu_grant: assert property ($rose(dfi_out.phyupd_ack) |-> $past(dfi_in.phyupd_req, 3))
		else $error("phy update ack without request");
	a_pu_held_off: assert property (dfi_out.ctrlupd_req && !dfi_out.phyupd_ack |=> !dfi_out.phyupd_ack)
		else $error("phy update ack during control update");
	a_pu_release: assert property ($fell(dfi_in.phyupd_req) && dfi_out.phyupd_ack |-> ##3 !dfi_out.phyupd_ack)
		else $error("phy update ack not released");
	a_clk_copy: assert property (reg_wr && reg_addr == `DTUM_A_CUL |->
		##2 dfi_out.dram_clk_disable == $past(reg_wdata[1:0], 2))
		else $error("clock disable strobe not copied");
	a_clk_stop: assert property ($rose(mem_clk_off[0]) |-> $past(dfi_out.dram_clk_disable[0]))
		else $error("memory clock stopped without strobe");
	a_clk_start: assert property ($fell(mem_clk_off[0]) |-> !$past(dfi_out.dram_clk_disable[0]))
		else $error("memory clock started with strobe high");
endmodule // dtum_checker

// ===== tb/dtum_phy_model.sv
// behavioural phy on the dfi update pins
// assumes go is a one-cycle pulse from the bench; read valid follows vld one cycle later
`timescale 1ns/1ps
module dtum_phy_model import dtum_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// bench control
	input wire logic go,
	input wire logic [1:0] typ,
	input wire logic [3:0] hold,
	input wire logic vld,
	// dfi
	input wire dtum_dfi_out_t dfi_out,
	output dtum_dfi_in_t dfi_in
);
	logic [3:0] cnt_q;
	// acks follow requests; phy request held until acked, then hold cycles more
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dfi_in <= '0;
			cnt_q <= 4'h0;
		end else begin
			dfi_in.ctrlupd_ack <= dfi_out.ctrlupd_req;
			dfi_in.rddata_valid <= vld;
			if (go) begin
				dfi_in.phyupd_req <= 1'b1;
				dfi_in.phyupd_type <= typ;
				cnt_q <= hold;
			end else if (dfi_in.phyupd_req && dfi_out.phyupd_ack) begin
				if (cnt_q == 4'h0) begin
					dfi_in.phyupd_req <= 1'b0;
					dfi_in.phyupd_type <= ~dfi_in.phyupd_type; // released type is not left at last value
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
		end
	end
endmodule // dtum_phy_model

// ===== tb/tb_dfi_timing_update_monitor.sv
// self-checking bench for the dfi timing and update monitor
// assumes the phy model answers updates; the checker is bound at the foot
`timescale 1ns/1ps
`include "dtum_regs.svh"
module tb_dfi_timing_update_monitor import dtum_pkg::*;;
	logic sys_clk, rst_b, reg_wr, reg_rd, update_irq, phy_go, phy_vld;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [1:0] mem_clk_off, phy_type;
	logic [3:0] phy_hold;
	dtum_core_t core_in;
	dtum_dfi_in_t dfi_in;
	dtum_dfi_out_t dfi_out;
	int mismatches = 0, n_checks = 0, n_irq = 0, cyc = 0, n, m;
	dtum_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_in(core_in), .dfi_in(dfi_in), .dfi_out(dfi_out),
		.mem_clk_off(mem_clk_off), .update_irq(update_irq));
	dtum_phy_model u_phy (.sys_clk(sys_clk), .rst_b(rst_b), .go(phy_go), .typ(phy_type), .hold(phy_hold),
		.vld(phy_vld), .dfi_out(dfi_out), .dfi_in(dfi_in));
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// interrupt pulse count and run ceiling
	always @(posedge sys_clk) begin
		n_irq <= n_irq + int'(update_irq === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// waits, reads the error field, checks interrupts, then clears
	task automatic chk_err(input string w, input logic [6:0] e);
		int k;
		k = n_irq;
		repeat (30) @(posedge sys_clk);
		rd(`DTUM_A_LAT);
		chk(w, {25'h0, e}, {25'h0, rv[14:8]});
		chk("irq", 32'(e != 7'h00), 32'(n_irq != k));
		wr(`DTUM_A_CMD, 32'h0000_7f00);
	endtask
	task automatic t_regs();
		logic [31:0] ad [12] = '{`DTUM_A_DLL, `DTUM_A_LAT, `DTUM_A_CUL, `DTUM_A_P01, `DTUM_A_P23, `DTUM_A_ACK,
			`DTUM_A_PER, `DTUM_A_CLK, `DTUM_A_WLE, `DTUM_A_WLR, `DTUM_A_WLM, 32'h4000_d5fc};
		logic [31:0] rs [12] = '{0, 0, 32'h0000_0400, 0, 0, 0, 0, 32'h0002_0000, 0, 0, 0, 0};
		logic [31:0] on [12] = '{32'hffff_ff00, 32'h003f_0000, 32'h3fff_0403, 32'hffff_ffff, 32'hffff_ffff,
			32'h0000_3fff, 32'hffff_ffff, 32'h0f0f_3f3f, 0, 0, 0, 0};
		for (int i = 0; i < 12; i++) begin
			rd(ad[i]);
			chk("reset value", rs[i], rv);
			if (i < 8 || i == 11) begin
				wr(ad[i], 32'hffff_ffff);
				rd(ad[i]);
				chk("all ones", on[i], rv);
				wr(ad[i], rs[i]);
			end
		end
		core_in.mem_rst_valid <= 1'b1;
		rd(`DTUM_A_DLL);
		chk("reset valid", 32'h0000_0001, rv);
	endtask
	task automatic t_lat();
		core_in.cas_lat <= 6'd10;
		core_in.wr_lat <= 6'd7;
		wr(`DTUM_A_CLK, 32'h0002_0305);
		rd(`DTUM_A_LAT);
		chk("latencies", 32'h0800_0008, rv);
		core_in.cas_lat <= 6'd1;
		rd(`DTUM_A_LAT);
		chk("latency floor", 32'h0000_0008, rv);
	endtask
	task automatic t_clk();
		wr(`DTUM_A_CLK, 32'h0302_0000);
		wr(`DTUM_A_WLE, 32'h0000_0005);
		for (int cs = 0; cs < 2; cs++) begin
			wr(`DTUM_A_CUL, 32'(1 << cs));
			for (n = 0; n < 9 && dfi_out.dram_clk_disable[cs] !== 1'b1; n++) tick();
			chk("strobe", 32'(1 << cs), 32'(dfi_out.dram_clk_disable));
			for (n = 0; n < 20 && mem_clk_off[cs] !== 1'b1; n++) tick();
			chk("off delay", 32'd3, 32'(n));
			wr(`DTUM_A_CUL, 32'h0000_0000);
			for (n = 0; n < 9 && dfi_out.dram_clk_disable[cs] !== 1'b0; n++) tick();
			for (n = 0; n < 20 && mem_clk_off[cs] !== 1'b0; n++) tick();
			chk("on delay", 32'd5, 32'(n));
		end
	endtask
	task automatic t_cu();
		for (int i = 0; i < 2; i++) begin
			wr(`DTUM_A_CUL, i ? 32'h0002_0000 : 32'h0000_0000);
			@(posedge sys_clk);
			core_in.ctrlupd_want <= 1'b1;
			@(posedge sys_clk);
			core_in.ctrlupd_want <= 1'b0;
			chk_err("update max", i ? 7'h02 : 7'h00);
		end
		wr(`DTUM_A_CUL, 32'h0000_0000);
		wr(`DTUM_A_PER, 32'd20);
		for (n = 0; n < 40 && dfi_out.ctrlupd_req !== 1'b1; n++) tick();
		for (n = 0; n < 40 && dfi_out.ctrlupd_req !== 1'b0; n++) tick();
		for (m = n; m < 80 && dfi_out.ctrlupd_req !== 1'b1; m++) tick();
		chk("period kept", 32'h1, 32'(m <= 20));
		chk_err("period", 7'h00);
		wr(`DTUM_A_PER, 32'h0000_0000);
		// software request starts an update one edge after the write lands
		repeat (8) tick();
		wr(`DTUM_A_CMD, 32'h0000_0001);
		for (n = 0; n < 9 && dfi_out.ctrlupd_req !== 1'b1; n++) tick();
		chk("sw request", 32'd1, 32'(n));
		// a period shorter than the request length must overrun
		wr(`DTUM_A_PER, 32'd3);
		chk_err("period over", 7'h01);
		wr(`DTUM_A_PER, 32'h0000_0000);
		wr(`DTUM_A_CMD, 32'h0000_7f00);
	endtask
	// read valid window: in time, missed, long window seen early and then late
	task automatic t_rd();
		wr(`DTUM_A_CLK, 32'h0302_0002);
		for (int i = 0; i < 4; i++) begin
			wr(`DTUM_A_LAT, i < 2 ? 32'h0002_0000 : 32'h003f_0000);
			@(posedge sys_clk);
			core_in.rddata_en <= (i != 3);
			phy_vld <= (i == 0);
			@(posedge sys_clk);
			core_in.rddata_en <= 1'b0;
			phy_vld <= 1'b0;
			repeat (i == 3 ? 60 : 12) @(posedge sys_clk);
			rd(`DTUM_A_CMD);
			chk("read late", 32'(i == 1 || i == 3), 32'(rv[16]));
			if (i != 2)
				wr(`DTUM_A_CMD, 32'h0001_0000);
		end
	endtask
	task automatic t_phy();
		wr(`DTUM_A_P01, 32'h0002_0002);
		wr(`DTUM_A_P23, 32'h0002_0002);
		for (int t = 0; t < 5; t++) begin
			if (t == 4)
				wr(`DTUM_A_P01, 32'h0000_0000);
			@(posedge sys_clk);
			phy_type <= 2'(t % 4 + t / 4);
			phy_hold <= 4'h8;
			phy_go <= 1'b1;
			@(posedge sys_clk);
			phy_go <= 1'b0;
			chk_err("type limit", t < 4 ? 7'(4 << t) : 7'h00);
		end
		wr(`DTUM_A_P23, 32'h0000_0000);
		wr(`DTUM_A_ACK, 32'h0000_0001);
		@(posedge sys_clk);
		core_in.ctrlupd_want <= 1'b1;
		phy_hold <= 4'h0;
		phy_go <= 1'b1;
		@(posedge sys_clk);
		core_in.ctrlupd_want <= 1'b0;
		phy_go <= 1'b0;
		chk_err("ack wait", 7'h40);
	endtask
	// reset, then the scenarios
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 32'h0000_0000;
		reg_wdata = 32'h0000_0000;
		core_in = '0;
		phy_go = 1'b0;
		phy_vld = 1'b0;
		phy_type = 2'b00;
		phy_hold = 4'h0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_regs();
		t_lat();
		t_clk();
		t_cu();
		t_phy();
		t_rd();
		give_verdict();
	end
endmodule // tb_dfi_timing_update_monitor
bind dtum_top dtum_checker #(.CTRLUPD_MIN(CTRLUPD_MIN)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.core_in(core_in), .dfi_in(dfi_in), .dfi_out(dfi_out), .mem_clk_off(mem_clk_off), .update_irq(update_irq));
